//--- verilog/apo_pkg.sv
// What this block does
// - Two-to-one interpolation, samples delayed half period.
// - Latch newest interpolated sample at chip-select fall.
// - Three arming modes chosen by configuration field.
// - After error, stretch runs; reads do not update.
// - Moving average over k offset-cancelled samples.
// - New sample only at response chip-select fall.
// - Average meets either threshold: arm, load stretch.
// - Count mode: hit increments counter, miss clears.
// - Counter reaching limit arms and loads stretch.
// - Unfiltered mode compares newest sample, thresholds inclusive.
// - Unfiltered output only during that axis's response.
// - No pulse stretching in unfiltered mode.
// - Stretch field zero: output follows arming condition.
// - Nonzero stretch: output while counter nonzero.
// - Arming output polarity selectable high or low.
// - Upper nine bits drive 8 MHz pulse-code output.
package apo_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ          = 50;
    localparam int PCM_MHZ          = 8;
    localparam int STRETCH_T1_US    = 20;
    localparam int STRETCH_T2_US    = 40;
    localparam int STRETCH_T3_US    = 80;
    localparam int STRETCH_CYC1     = STRETCH_T1_US * CLK_MHZ;
    localparam int STRETCH_CYC2     = STRETCH_T2_US * CLK_MHZ;
    localparam int STRETCH_CYC3     = STRETCH_T3_US * CLK_MHZ;
    localparam int STRETCH_W        = 12;
    localparam int PERIOD_W         = 16;
    localparam int PCM_ACC_W        = 6;

    // ************************************************************
    // Widths, field positions and reset values
    // ************************************************************
    localparam int SAMPLE_W         = 10;
    localparam int PCM_W            = 9;
    localparam int THR_W            = 8;
    localparam int HIST_DEPTH       = 8;
    localparam int SUM_W            = 13;
    localparam int CNT_W            = 3;
    localparam int THR_LSB          = 2;
    localparam int AXIS_X           = 0;
    localparam int AXIS_Y           = 1;
    localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 10'h000;
    localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0]
    {
        APO_ARM_OFF    = 2'b00,
        APO_ARM_MAVG   = 2'b01,
        APO_ARM_COUNT  = 2'b10,
        APO_ARM_UNFILT = 2'b11
    } apo_arm_mode_t;

    typedef struct packed
    {
        logic [1:0]       window_size;
        logic [1:0]       stretch_time;
        logic [THR_W-1:0] thr_pos;
        logic [THR_W-1:0] thr_neg;
    } apo_axis_cfg_t;

    typedef struct packed
    {
        apo_arm_mode_t mode;
        logic          active_low;
        logic          pcm_en;
    } apo_dev_cfg_t;

    typedef struct packed
    {
        logic                acc;
        logic                axis;
        logic                error;
    } apo_resp_t;

    // ************************************************************
    // Shared functions
    // ************************************************************
    function automatic logic thr_hit(input logic signed [SAMPLE_W-1:0] v,
                                     input apo_axis_cfg_t c);
        logic signed [THR_W:0] v8;
        logic signed [THR_W:0] pos;
        logic signed [THR_W:0] neg;
        v8  = {v[SAMPLE_W-1], v[SAMPLE_W-1:THR_LSB]};
        pos = {1'b0, c.thr_pos};
        neg = (THR_W+1)'(-$signed({1'b0, c.thr_neg}));
        thr_hit = (v8 >= pos) || (v8 <= neg);
    endfunction

    function automatic logic [STRETCH_W-1:0] stretch_load(input logic [1:0] f);
        case (f)
            2'b01:   stretch_load = STRETCH_W'(STRETCH_CYC1);
            2'b10:   stretch_load = STRETCH_W'(STRETCH_CYC2);
            2'b11:   stretch_load = STRETCH_W'(STRETCH_CYC3);
            default: stretch_load = '0;
        endcase
    endfunction

endpackage

//--- verilog/apo_interp.sv
`timescale 1ns/1ps
`default_nettype none
module apo_interp
    import apo_pkg::*;
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    input  wire logic                       valid_i,
    input  wire logic signed [SAMPLE_W-1:0] sample_i,
    output logic signed [SAMPLE_W-1:0]      interp_o
);

    logic signed [SAMPLE_W-1:0] cur_r, cur_nxt, out_r, out_nxt;
    logic [PERIOD_W-1:0]        per_cnt_r, per_cnt_nxt, per_r, per_nxt;
    logic [PERIOD_W-1:0]        half_r, half_nxt;
    logic                       pend_r, pend_nxt;
    logic signed [SAMPLE_W:0]   sum;

    // ************************************************************
    // Half-period delay and midpoint
    // ************************************************************
    always_comb
    begin
        sum         = (SAMPLE_W+1)'(cur_r) + (SAMPLE_W+1)'(sample_i) + 11'sh001;
        cur_nxt     = cur_r;
        out_nxt     = out_r;
        per_nxt     = per_r;
        per_cnt_nxt = per_cnt_r;
        half_nxt    = half_r;
        pend_nxt    = pend_r;
        if (valid_i)
        begin
            // The midpoint is shown at arrival, the true sample half a
            // period later, so the period must first be learned.
            out_nxt     = SAMPLE_W'(sum >>> 1);
            cur_nxt     = sample_i;
            per_nxt     = per_cnt_r;
            per_cnt_nxt = PERIOD_RST;
            half_nxt    = per_r >> 1;
            pend_nxt    = 1'b1;
        end
        else
        begin
            if (per_cnt_r != '1)
                per_cnt_nxt = per_cnt_r + 16'h0001;
            if (pend_r)
            begin
                if (half_r == PERIOD_RST)
                begin
                    out_nxt  = cur_r;
                    pend_nxt = 1'b0;
                end
                else
                    half_nxt = half_r - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cur_r     <= SAMPLE_RST;
            out_r     <= SAMPLE_RST;
            per_r     <= PERIOD_RST;
            per_cnt_r <= PERIOD_RST;
            half_r    <= PERIOD_RST;
            pend_r    <= 1'b0;
        end
        else if (ce_i)
        begin
            cur_r     <= cur_nxt;
            out_r     <= out_nxt;
            per_r     <= per_nxt;
            per_cnt_r <= per_cnt_nxt;
            half_r    <= half_nxt;
            pend_r    <= pend_nxt;
        end
    end

    assign interp_o = out_r;

endmodule
`default_nettype wire

//--- verilog/apo_pcm.sv
`timescale 1ns/1ps
`default_nettype none
module apo_pcm
    import apo_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire logic [PCM_W-1:0]    value_i,
    output logic                     pcm_o
);

    logic [PCM_ACC_W-1:0] tick_acc_r, tick_acc_nxt;
    logic [PCM_W-1:0]     sd_acc_r, sd_acc_nxt;
    logic                 pcm_r, pcm_nxt;
    logic                 tick;
    logic [PCM_W:0]       sd_sum;
    logic [PCM_ACC_W:0]   tick_sum;

    // ************************************************************
    // 8 MHz tick and first-order density modulator
    // ************************************************************
    always_comb
    begin
        // A fractional divider keeps the mean rate exact; the tick
        // spacing jitters by one clock because 50 is not a multiple of 8.
        tick_sum     = (PCM_ACC_W+1)'(tick_acc_r) + (PCM_ACC_W+1)'(PCM_MHZ);
        tick         = tick_sum >= (PCM_ACC_W+1)'(CLK_MHZ);
        tick_acc_nxt = tick ? PCM_ACC_W'(tick_sum - (PCM_ACC_W+1)'(CLK_MHZ))
                            : PCM_ACC_W'(tick_sum);
        // Signed value becomes offset binary so zero g gives half density.
        sd_sum       = (PCM_W+1)'(sd_acc_r)
                     + (PCM_W+1)'({~value_i[PCM_W-1], value_i[PCM_W-2:0]});
        sd_acc_nxt   = sd_acc_r;
        pcm_nxt      = pcm_r;
        if (tick)
        begin
            sd_acc_nxt = sd_sum[PCM_W-1:0];
            pcm_nxt    = sd_sum[PCM_W];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tick_acc_r <= '0;
            sd_acc_r   <= '0;
            pcm_r      <= 1'b0;
        end
        else if (ce_i)
        begin
            tick_acc_r <= tick_acc_nxt;
            sd_acc_r   <= sd_acc_nxt;
            pcm_r      <= pcm_nxt;
        end
    end

    assign pcm_o = pcm_r;

endmodule
`default_nettype wire

//--- verilog/apo_arm_pcm.sv
`timescale 1ns/1ps
`default_nettype none
module apo_arm_pcm
    import apo_pkg::*;
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    input  wire logic                       cs_n_i,
    input  wire apo_resp_t                  resp_i,
    input  wire logic                       sample_valid_i,
    input  wire logic signed [SAMPLE_W-1:0] sample_x_i,
    input  wire logic signed [SAMPLE_W-1:0] sample_y_i,
    input  wire logic signed [SAMPLE_W-1:0] oc_x_i,
    input  wire logic signed [SAMPLE_W-1:0] oc_y_i,
    input  wire apo_dev_cfg_t               dev_cfg_i,
    input  wire apo_axis_cfg_t              cfg_x_i,
    input  wire apo_axis_cfg_t              cfg_y_i,
    output logic [SAMPLE_W-1:0]             acc_data_o,
    output logic                            acc_latch_o,
    output logic                            arm_x_o,
    output logic                            arm_y_o
);

    logic signed [SAMPLE_W-1:0] interp [2];
    logic signed [SAMPLE_W-1:0] oc [2];
    logic                       pcm [2];
    apo_axis_cfg_t              cfg [2];

    assign oc[AXIS_X]  = oc_x_i;
    assign oc[AXIS_Y]  = oc_y_i;
    assign cfg[AXIS_X] = cfg_x_i;
    assign cfg[AXIS_Y] = cfg_y_i;

    // ************************************************************
    // Interpolation and pulse-code generators
    // ************************************************************
    apo_interp u_interp_x
    (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .valid_i  (sample_valid_i),
        .sample_i (sample_x_i),
        .interp_o (interp[AXIS_X])
    );

    apo_interp u_interp_y
    (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .valid_i  (sample_valid_i),
        .sample_i (sample_y_i),
        .interp_o (interp[AXIS_Y])
    );

    apo_pcm u_pcm_x
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .value_i (oc_x_i[SAMPLE_W-1:SAMPLE_W-PCM_W]),
        .pcm_o   (pcm[AXIS_X])
    );

    apo_pcm u_pcm_y
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .value_i (oc_y_i[SAMPLE_W-1:SAMPLE_W-PCM_W]),
        .pcm_o   (pcm[AXIS_Y])
    );

    // ************************************************************
    // Chip-select synchroniser
    // ************************************************************
    logic [2:0] cs_sync_r, cs_sync_nxt;
    logic       cs_lvl_r, cs_lvl_nxt;
    logic       cs_fall;

    always_comb
    begin
        cs_sync_nxt = {cs_sync_r[1:0], cs_n_i};
        cs_lvl_nxt  = cs_lvl_r;
        cs_fall     = 1'b0;
        if (cs_sync_r[1] == cs_sync_r[2])
        begin
            cs_lvl_nxt = cs_sync_r[2];
            cs_fall    = cs_lvl_r && !cs_sync_r[2];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cs_sync_r <= 3'h7;
            cs_lvl_r  <= 1'b1;
        end
        else if (ce_i)
        begin
            cs_sync_r <= cs_sync_nxt;
            cs_lvl_r  <= cs_lvl_nxt;
        end
    end

    // ************************************************************
    // Response data latch
    // ************************************************************
    logic [SAMPLE_W-1:0] acc_data_r, acc_data_nxt;
    logic                acc_latch_r, acc_latch_nxt;

    always_comb
    begin
        acc_data_nxt  = acc_data_r;
        acc_latch_nxt = 1'b0;
        if (cs_fall && resp_i.acc)
        begin
            // Latching at the response edge, not the request, keeps
            // latency below one sample period.
            acc_data_nxt  = interp[resp_i.axis];
            acc_latch_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            acc_data_r  <= SAMPLE_RST;
            acc_latch_r <= 1'b0;
        end
        else if (ce_i)
        begin
            acc_data_r  <= acc_data_nxt;
            acc_latch_r <= acc_latch_nxt;
        end
    end

    // ************************************************************
    // Arming evaluation per axis
    // ************************************************************
    logic signed [SAMPLE_W-1:0] hist_r [2][HIST_DEPTH];
    logic signed [SAMPLE_W-1:0] hist_nxt [2][HIST_DEPTH];
    logic [CNT_W-1:0]           cnt_r [2];
    logic [CNT_W-1:0]           cnt_nxt [2];
    logic [STRETCH_W-1:0]       str_r [2];
    logic [STRETCH_W-1:0]       str_nxt [2];
    logic                       cond_r [2];
    logic                       cond_nxt [2];
    logic                       arm_r [2];
    logic                       arm_nxt [2];
    logic signed [SUM_W-1:0]    sum;
    logic signed [SAMPLE_W-1:0] avg;
    logic                       eval;
    logic                       lvl;

    always_comb
    begin
        sum  = '0;
        avg  = '0;
        eval = 1'b0;
        lvl  = 1'b0;
        for (int a = 0; a < 2; a++)
        begin
            hist_nxt[a] = hist_r[a];
            cnt_nxt[a]  = cnt_r[a];
            cond_nxt[a] = cond_r[a];
            str_nxt[a]  = str_r[a];
            if (str_r[a] != '0)
                str_nxt[a] = str_r[a] - 12'h001;
            // A pending error blocks evaluation but the stretch above
            // keeps running down.
            eval = cs_fall && resp_i.acc && !resp_i.error
                && (resp_i.axis == 1'(a));
            if (eval)
            begin
                case (dev_cfg_i.mode)
                    APO_ARM_MAVG:
                    begin
                        for (int i = HIST_DEPTH - 1; i > 0; i--)
                            hist_nxt[a][i] = hist_r[a][i-1];
                        hist_nxt[a][0] = oc[a];
                        sum = '0;
                        for (int i = 0; i < HIST_DEPTH; i++)
                            if (i < (1 << cfg[a].window_size))
                                sum = sum + SUM_W'(hist_nxt[a][i]);
                        avg = SAMPLE_W'(sum >>> cfg[a].window_size);
                        cond_nxt[a] = thr_hit(avg, cfg[a]);
                    end
                    APO_ARM_COUNT:
                    begin
                        if (thr_hit(oc[a], cfg[a]))
                        begin
                            if (cnt_r[a] != '1)
                                cnt_nxt[a] = cnt_r[a] + 3'h1;
                        end
                        else
                            cnt_nxt[a] = '0;
                        cond_nxt[a] = cnt_nxt[a]
                            >= CNT_W'({1'b0, cfg[a].window_size} + 3'h1);
                    end
                    APO_ARM_UNFILT:
                        cond_nxt[a] = thr_hit(interp[a], cfg[a]);
                    default:
                        cond_nxt[a] = 1'b0;
                endcase
                if (cond_nxt[a] && (dev_cfg_i.mode != APO_ARM_UNFILT))
                    str_nxt[a] = stretch_load(cfg[a].stretch_time);
            end
            case (dev_cfg_i.mode)
                APO_ARM_UNFILT:
                    lvl = cond_r[a] && !cs_lvl_r && resp_i.acc
                       && (resp_i.axis == 1'(a));
                APO_ARM_MAVG, APO_ARM_COUNT:
                    if (cfg[a].stretch_time == 2'b00)
                        lvl = cond_r[a];
                    else
                        lvl = str_r[a] != '0;
                default:
                    lvl = 1'b0;
            endcase
            if (dev_cfg_i.pcm_en)
                arm_nxt[a] = pcm[a];
            else
                arm_nxt[a] = lvl ^ dev_cfg_i.active_low;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int a = 0; a < 2; a++)
            begin
                for (int i = 0; i < HIST_DEPTH; i++)
                    hist_r[a][i] <= SAMPLE_RST;
                cnt_r[a]  <= '0;
                str_r[a]  <= '0;
                cond_r[a] <= 1'b0;
                arm_r[a]  <= 1'b0;
            end
        end
        else if (ce_i)
        begin
            for (int a = 0; a < 2; a++)
            begin
                hist_r[a] <= hist_nxt[a];
                cnt_r[a]  <= cnt_nxt[a];
                str_r[a]  <= str_nxt[a];
                cond_r[a] <= cond_nxt[a];
                arm_r[a]  <= arm_nxt[a];
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign acc_data_o  = acc_data_r;
    assign acc_latch_o = acc_latch_r;
    assign arm_x_o     = arm_r[AXIS_X];
    assign arm_y_o     = arm_r[AXIS_Y];

endmodule
`default_nettype wire

//--- verification/apo_arm_pcm_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module apo_arm_pcm_assertions
    import apo_pkg::*;
(
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                cs_n_i,
    input wire apo_resp_t           resp_i,
    input wire apo_dev_cfg_t        dev_cfg_i,
    input wire apo_axis_cfg_t       cfg_x_i,
    input wire logic [SAMPLE_W-1:0] acc_data_o,
    input wire logic                acc_latch_o,
    input wire logic                arm_x_o,
    input wire logic                arm_y_o
);
    // ************************************************************
    // Helper logic
    // ************************************************************
    // Counts how long the X pin has been active; it saturates so that a
    // stuck pin cannot wrap round and look like a fresh pulse.
    logic [11:0] hold_r;
    wire logic   unf = dev_cfg_i.mode == APO_ARM_UNFILT && !dev_cfg_i.pcm_en;
    wire logic   act_x = arm_x_o ^ dev_cfg_i.active_low;
    wire logic   str_on = cfg_x_i.stretch_time == 2'b01 && !dev_cfg_i.pcm_en
                 && dev_cfg_i.mode inside {APO_ARM_MAVG, APO_ARM_COUNT};
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i || !act_x)
            hold_r <= '0;
        else if (hold_r != 12'hFFF)
            hold_r <= hold_r + 12'h001;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ************************************************************
    // Properties
    // ************************************************************
    property p_once; acc_latch_o |=> !acc_latch_o; endproperty
    a_once: assert property (p_once)
        else $error("latch pulse longer than one cycle");
    property p_cause;
        acc_latch_o |-> !$past(cs_n_i) && $past(resp_i.acc);
    endproperty
    a_cause: assert property (p_cause)
        else $error("latch without an acceleration response");
    property p_fall; $fell(cs_n_i) && resp_i.acc |-> ##[2:6] acc_latch_o;
    endproperty
    a_fall: assert property (p_fall)
        else $error("no latch after select fall");
    property p_keep; !acc_latch_o |-> $stable(acc_data_o); endproperty
    a_keep: assert property (p_keep)
        else $error("data changed without latch");
    property p_unf_idle;
        (unf && cs_n_i && $stable(dev_cfg_i))[*6] |->
            arm_x_o == dev_cfg_i.active_low && arm_y_o == dev_cfg_i.active_low;
    endproperty
    a_unf_idle: assert property (p_unf_idle)
        else $error("arming pin active outside a response");
    property p_unf_y;
        (unf && resp_i.acc && !resp_i.axis && $stable(dev_cfg_i))[*6] |->
            arm_y_o == dev_cfg_i.active_low;
    endproperty
    a_unf_y: assert property (p_unf_y)
        else $error("Y pin active during an X response");
    property p_off;
        (dev_cfg_i.mode == APO_ARM_OFF && !dev_cfg_i.pcm_en
         && $stable(dev_cfg_i))[*8] |->
            arm_x_o == dev_cfg_i.active_low && arm_y_o == dev_cfg_i.active_low;
    endproperty
    a_off: assert property (p_off)
        else $error("arming pin active with arming off");
    property p_hold; $fell(act_x) && str_on |-> hold_r >= 12'h3DE; endproperty
    a_hold: assert property (p_hold)
        else $error("stretched pulse ended early");
endmodule
`default_nettype wire

//--- verification/apo_mst_model.sv
`timescale 1ns/1ps
`default_nettype none
module apo_mst_model
    import apo_pkg::*;
#(
    parameter int LINK_NS = 160
)
(
    output var logic      cs_n_o,
    output var apo_resp_t resp_o
);
    // ************************************************************
    // Frame driver
    // ************************************************************
    // Idle flags are the inverse of the last frame's, so a design that
    // reads them outside a frame is not saved by luck.
    initial
    begin
        cs_n_o = 1'b1;
        resp_o = '{acc: 1'b0, axis: 1'b1, error: 1'b1};
    end
    task automatic xfer(input logic ax, input logic er);
        #3 resp_o = '{acc: 1'b1, axis: ax, error: er};
        #10 cs_n_o = 1'b0;
        #(2 * LINK_NS) cs_n_o = 1'b1;
        #(LINK_NS) resp_o = '{acc: 1'b0, axis: !ax, error: !er};
        #(LINK_NS);
    endtask
endmodule
`default_nettype wire

//--- verification/apo_arm_pcm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module apo_arm_pcm_tb_top
    import apo_pkg::*;
;
    logic                       clk_i;
    logic                       rst_i;
    logic                       cs_n;
    apo_resp_t                  resp;
    logic                       sv;
    logic signed [SAMPLE_W-1:0] sx, sy, ox, oy;
    apo_dev_cfg_t               dcfg;
    apo_axis_cfg_t              cx;
    logic [SAMPLE_W-1:0]        data, got;
    logic                       latch, arm_x, arm_y;
    int                         num_errors = 0;
    int                         n_compared = 0;
    int                         n_lat = 0;
    apo_arm_pcm u_apo_arm_pcm (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .cs_n_i(cs_n), .resp_i(resp), .sample_valid_i(sv), .sample_x_i(sx),
        .sample_y_i(sy), .oc_x_i(ox), .oc_y_i(oy), .dev_cfg_i(dcfg),
        .cfg_x_i(cx), .cfg_y_i(cx), .acc_data_o(data), .acc_latch_o(latch),
        .arm_x_o(arm_x), .arm_y_o(arm_y));
    apo_mst_model #(.LINK_NS(160)) u_mst (.cs_n_o(cs_n), .resp_o(resp));
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
        if (latch)
        begin
            got   <= data;
            n_lat <= n_lat + 1;
        end
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [9:0] a, input logic [9:0] e);
        n_compared++;
        if (a !== e)
        begin
            $display("unexpected %0t: got %h exp %h", $time, a, e);
            num_errors++;
        end
    endtask
    task automatic arms(input logic ex, input logic ey);
        chk(10'(arm_x), 10'(ex ^ dcfg.active_low));
        chk(10'(arm_y), 10'(ey ^ dcfg.active_low));
    endtask
    // Pins are read at the falling edge, clear of the registers' update.
    task automatic ca(input logic ex, input logic ey);
        @(negedge clk_i);
        arms(ex, ey);
        @(posedge clk_i);
    endtask
    task automatic rq(input logic ax, input logic er);
        int n0;
        n0 = n_lat;
        u_mst.xfer(ax, er);
        @(posedge clk_i);
        chk(10'(n_lat - n0), 10'h001);
    endtask
    task automatic mid(input logic ax, input logic ex, input logic ey);
        fork
            rq(ax, 1'b0);
            begin
                repeat (12) @(negedge clk_i);
                arms(ex, ey);
            end
        join
    endtask
    task automatic smp(input logic [9:0] x, input logic [9:0] y, int w);
        sv <= 1'b1;
        sx <= x;
        sy <= y;
        @(posedge clk_i);
        sv <= 1'b0;
        repeat (w) @(posedge clk_i);
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_int();
        smp(10'h064, 10'h0C8, 39);
        smp(10'h064, 10'h0C8, 39);
        smp(10'h3F9, 10'h0CB, 1);
        rq(1'b0, 1'b0);
        chk(got, 10'h02F);
        rq(1'b1, 1'b0);
        chk(got, 10'h0CB);
        $display("test interp done");
    endtask
    task automatic t_unf();
        for (int p = 0; p < 2; p++)
        begin
            dcfg <= '{APO_ARM_UNFILT, p[0], 1'b0};
            smp(10'h040, 10'h3C0, 39);
            smp(10'h040, 10'h3C0, 5);
            mid(1'b0, 1'b1, 1'b0);
            mid(1'b1, 1'b0, 1'b1);
            ca(1'b0, 1'b0);
            smp(10'h03F, 10'h3C4, 39);
            smp(10'h03F, 10'h3C4, 5);
            mid(1'b0, 1'b0, 1'b0);
            mid(1'b1, 1'b0, 1'b0);
        end
        $display("test unfiltered done");
    endtask
    task automatic t_avg();
        dcfg <= '{APO_ARM_MAVG, 1'b0, 1'b0};
        ox <= 10'h040;
        rq(1'b0, 1'b0);
        ca(1'b0, 1'b0);
        rq(1'b0, 1'b0);
        ca(1'b1, 1'b0);
        ox <= 10'h000;
        rq(1'b0, 1'b0);
        ca(1'b0, 1'b0);
        $display("test average done");
    endtask
    task automatic t_str();
        cx <= '{2'b01, 2'b01, 8'h10, 8'h10};
        ox <= 10'h040;
        rq(1'b0, 1'b0);
        rq(1'b0, 1'b0);
        ca(1'b1, 1'b0);
        repeat (470) @(posedge clk_i);
        rq(1'b0, 1'b1);
        repeat (440) @(posedge clk_i);
        ca(1'b1, 1'b0);
        repeat (60) @(posedge clk_i);
        ca(1'b0, 1'b0);
        $display("test stretch done");
    endtask
    task automatic t_cnt();
        logic [9:0] v [6] = '{10'h040, 10'h040, 10'h000, 10'h000,
                              10'h040, 10'h040};
        logic       e [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        dcfg <= '{APO_ARM_OFF, 1'b0, 1'b0};
        cx <= '{2'b01, 2'b00, 8'h10, 8'h10};
        rq(1'b0, 1'b0);
        rq(1'b0, 1'b0);
        ca(1'b0, 1'b0);
        dcfg <= '{APO_ARM_COUNT, 1'b0, 1'b0};
        for (int i = 0; i < 6; i++)
        begin
            ox <= v[i];
            rq(1'b0, 1'b0);
            ca(e[i], 1'b0);
        end
        $display("test count done");
    endtask
    task automatic t_pcm();
        int nx;
        int ny;
        nx = 0;
        ny = 0;
        dcfg <= '{APO_ARM_OFF, 1'b0, 1'b1};
        ox <= 10'h1FF;
        oy <= 10'h200;
        repeat (20) @(posedge clk_i);
        repeat (400)
        begin
            @(negedge clk_i);
            nx += int'(arm_x);
            ny += int'(arm_y);
        end
        chk(10'(nx >= 380), 10'h001);
        chk(10'(ny <= 20), 10'h001);
        $display("test pcm done");
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // The tests need about 2500 cycles; eight times that means a hang.
    initial
    begin
        #400000;
        num_errors++;
        final_report();
    end
    initial
    begin
        rst_i = 1'b1;
        sv    = 1'b0;
        sx    = '0;
        sy    = '0;
        ox    = '0;
        oy    = '0;
        dcfg  = '{APO_ARM_OFF, 1'b0, 1'b0};
        cx    = '{2'b01, 2'b00, 8'h10, 8'h10};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_int();
        t_unf();
        t_avg();
        t_str();
        t_cnt();
        t_pcm();
        final_report();
    end
endmodule
bind apo_arm_pcm apo_arm_pcm_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cs_n_i(cs_n_i), .resp_i(resp_i), .dev_cfg_i(dev_cfg_i),
    .cfg_x_i(cfg_x_i), .acc_data_o(acc_data_o), .acc_latch_o(acc_latch_o),
    .arm_x_o(arm_x_o), .arm_y_o(arm_y_o));
`default_nettype wire
